/* inc/twi_regs.vh */
`ifndef TWI_REGS_VH
`define TWI_REGS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define REG_DATA_OFS 8'h00
`define REG_SLAVE_ADDR_OFS 8'h04
`define REG_STATUS_CTRL_OFS 8'h08
`define REG_MAIN_CTRL_OFS 8'h0C
// ----------------------------------------
// Status/control fields
// ----------------------------------------
`define SC_BYTE_DONE 7
`define SC_ADDR_MATCH 6
`define SC_BUS_BUSY 5
`define SC_TX_MODE 4
`define SC_ACK_TO_SEND 3
`define SC_READ_REQ 2
`define SC_ACK_RECEIVED 0
// ----------------------------------------
// Main control fields
// ----------------------------------------
`define MC_MODE_HI 7
`define MC_MODE_LO 5
`define MC_IF_ENABLE 1
`define MC_IRQ_ENABLE 0
`define MODE_TWO_WIRE 3'h6
// ----------------------------------------
// Reset values and bits per byte
// ----------------------------------------
`define RST_DATA 8'h00
`define RST_SLAVE_ADDR 8'h00
`define RST_MAIN_CTRL 8'h00
`define BITS_PER_BYTE 4'h8
`endif

/* src/sync_edge.v */
`timescale 1ns/100ps
module sync_edge (
  input wire ref_clk_i,
  input wire srst_i,
  input wire async_i,
  output wire level_o,
  output wire rise_o,
  output wire fall_o
);
  // ----------------------------------------
  // Two-stage synchroniser, then edge finder
  // ----------------------------------------
  reg meta_q;
  reg sync_q;
  reg prev_q;
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end
  assign level_o = sync_q;
  assign rise_o = sync_q & ~prev_q;
  assign fall_o = ~sync_q & prev_q;
endmodule // sync_edge

/* src/shift_byte.v */
`timescale 1ns/100ps
module shift_byte #(
  parameter W = 8
) (
  input wire ref_clk_i,
  input wire srst_i,
  input wire load_i,
  input wire [W-1:0] load_data_i,
  input wire shift_i,
  input wire bit_i,
  output wire msb_o,
  output wire [W-1:0] data_o
);
  // ----------------------------------------
  // MSB-first shifter, load wins over shift
  // ----------------------------------------
  reg [W-1:0] sh_q;
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      sh_q <= {W{1'b0}};
    end else if (load_i) begin
      sh_q <= load_data_i;
    end else if (shift_i) begin
      sh_q <= {sh_q[W-2:0], bit_i};
    end
  end
  assign msb_o = sh_q[W-1];
  assign data_o = sh_q;
endmodule // shift_byte

/* src/two_wire_slave_interface.v */
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`include "twi_regs.vh"
module two_wire_slave_interface (
  input wire ref_clk_i,
  input wire srst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  input wire scl_i,
  output wire scl_o,
  output wire scl_oe_o,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_o,
  output wire bus_irq_o
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_ACK_ADDR = 3'h2;
  localparam ST_STRETCH = 3'h3;
  localparam ST_RELEASE = 3'h4;
  localparam ST_DATA = 3'h5;
  localparam ST_ACK = 3'h6;
  localparam ST_WAIT_STOP = 3'h7;

  // ----------------------------------------
  // Line sampling
  // ----------------------------------------
  wire scl_lvl;
  wire scl_rise;
  wire scl_fall;
  wire sda_lvl;
  wire sda_rise;
  wire sda_fall;
  sync_edge u_scl_sync (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .async_i(scl_i),
    .level_o(scl_lvl),
    .rise_o(scl_rise),
    .fall_o(scl_fall)
  );
  sync_edge u_sda_sync (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .async_i(sda_i),
    .level_o(sda_lvl),
    .rise_o(sda_rise),
    .fall_o(sda_fall)
  );
  wire start_det = sda_fall & scl_lvl;
  wire stop_det = sda_rise & scl_lvl;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] data_q;
  reg [7:0] slave_addr_q;
  reg [7:0] main_ctrl_q;
  reg tx_mode_q;
  reg ack_to_send_q;
  reg byte_done_q;
  reg addr_match_q;
  reg bus_busy_q;
  reg read_req_q;
  reg ack_received_q;
  reg [2:0] state_q;
  reg [3:0] cnt_q;
  reg scl_oe_q;
  reg sda_oe_q;
  reg irq_q;
  reg pready_q;
  reg pslverr_q;
  reg [31:0] prdata_q;
  reg scl_o_q;
  reg sda_o_q;

  // Mode field must match as well, so a half-configured block keeps the pins quiet
  wire active = main_ctrl_q[`MC_IF_ENABLE] &
    (main_ctrl_q[`MC_MODE_HI:`MC_MODE_LO] == `MODE_TWO_WIRE);

  // ----------------------------------------
  // APB slave, one wait state
  // ----------------------------------------
  wire apb_done = psel_i & penable_i & pready_q;
  wire wr_en = apb_done & pwrite_i;
  wire rd_en = apb_done & ~pwrite_i;
  wire hit = (paddr_i == `REG_DATA_OFS) | (paddr_i == `REG_SLAVE_ADDR_OFS) |
    (paddr_i == `REG_STATUS_CTRL_OFS) | (paddr_i == `REG_MAIN_CTRL_OFS);
  wire wr_data = wr_en & (paddr_i == `REG_DATA_OFS);
  wire rd_data = rd_en & (paddr_i == `REG_DATA_OFS);
  wire [7:0] status_ctrl = {byte_done_q, addr_match_q, bus_busy_q, tx_mode_q,
    ack_to_send_q, read_req_q, 1'b0, ack_received_q};
  reg [7:0] rd_mux;
  always @* begin
    case (paddr_i)
      `REG_DATA_OFS: rd_mux = data_q;
      `REG_SLAVE_ADDR_OFS: rd_mux = slave_addr_q;
      `REG_STATUS_CTRL_OFS: rd_mux = status_ctrl;
      `REG_MAIN_CTRL_OFS: rd_mux = main_ctrl_q;
      default: rd_mux = 8'h00;
    endcase
  end
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= psel_i & penable_i & ~pready_q;
      pslverr_q <= psel_i & penable_i & ~pready_q & ~hit;
      if (psel_i & penable_i & ~pready_q) begin
        prdata_q <= {24'h000000, rd_mux};
      end
    end
  end

  // ----------------------------------------
  // Transmit byte
  // ----------------------------------------
  // A service write lands in the data register on this same edge, so the
  // shifter and the first bit take the bus word rather than the stale register
  wire [7:0] tx_byte = wr_data ? pwdata_i[7:0] : data_q;

  // ----------------------------------------
  // Shifter
  // ----------------------------------------
  wire sh_load;
  wire sh_shift;
  wire sh_msb;
  wire [7:0] sh_data;
  shift_byte #(.W(8)) u_shift (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .load_i(sh_load),
    .load_data_i(tx_byte),
    .shift_i(sh_shift),
    .bit_i(sda_lvl),
    .msb_o(sh_msb),
    .data_o(sh_data)
  );
  // Software service of the stretched clock: write in tx, dummy read in rx
  wire svc = (state_q == ST_STRETCH) & (tx_mode_q ? wr_data : rd_data);
  assign sh_load = svc & tx_mode_q;
  // Receive shifts on rise; transmit shifts on fall to expose the next bit
  assign sh_shift = ((state_q == ST_ADDR) & scl_rise) |
    ((state_q == ST_DATA) & ~tx_mode_q & scl_rise) |
    ((state_q == ST_DATA) & tx_mode_q & scl_fall & (cnt_q != `BITS_PER_BYTE));
  wire [7:0] addr_byte = {sh_data[6:0], sda_lvl};
  wire addr_eq = (addr_byte[7:1] == slave_addr_q[7:1]);

  // ----------------------------------------
  // Protocol engine
  // ----------------------------------------
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      bus_busy_q <= 1'b0;
      addr_match_q <= 1'b0;
      byte_done_q <= 1'b0;
      read_req_q <= 1'b0;
      ack_received_q <= 1'b0;
      irq_q <= 1'b0;
      data_q <= `RST_DATA;
      slave_addr_q <= `RST_SLAVE_ADDR;
      main_ctrl_q <= `RST_MAIN_CTRL;
      tx_mode_q <= 1'b0;
      ack_to_send_q <= 1'b0;
      scl_o_q <= 1'b0;
      sda_o_q <= 1'b0;
    end else begin
      irq_q <= 1'b0;
      if (wr_en & (paddr_i == `REG_SLAVE_ADDR_OFS)) begin
        slave_addr_q <= pwdata_i[7:0];
      end
      if (wr_en & (paddr_i == `REG_MAIN_CTRL_OFS)) begin
        main_ctrl_q <= pwdata_i[7:0];
      end
      if (wr_en & (paddr_i == `REG_STATUS_CTRL_OFS)) begin
        tx_mode_q <= pwdata_i[`SC_TX_MODE];
        ack_to_send_q <= pwdata_i[`SC_ACK_TO_SEND];
      end
      if (wr_data) begin
        data_q <= pwdata_i[7:0];
      end
      if (!active) begin
        state_q <= ST_IDLE;
        scl_oe_q <= 1'b0;
        sda_oe_q <= 1'b0;
        bus_busy_q <= 1'b0;
      end else if (stop_det) begin
        state_q <= ST_IDLE;
        scl_oe_q <= 1'b0;
        sda_oe_q <= 1'b0;
        bus_busy_q <= 1'b0;
      end else if (start_det) begin
        state_q <= ST_ADDR;
        cnt_q <= 4'h0;
        scl_oe_q <= 1'b0;
        sda_oe_q <= 1'b0;
        bus_busy_q <= 1'b1;
      end else begin
        case (state_q)
          ST_IDLE: begin
            cnt_q <= 4'h0;
          end
          ST_ADDR: begin
            if (scl_rise) begin
              cnt_q <= cnt_q + 4'h1;
              if (cnt_q == `BITS_PER_BYTE - 4'h1) begin
                addr_match_q <= addr_eq;
                read_req_q <= sda_lvl;
                irq_q <= addr_eq & main_ctrl_q[`MC_IRQ_ENABLE];
              end
            end else if (scl_fall & (cnt_q == `BITS_PER_BYTE)) begin
              if (addr_match_q) begin
                sda_oe_q <= 1'b1;
                state_q <= ST_ACK_ADDR;
              end else begin
                state_q <= ST_WAIT_STOP;
              end
            end
          end
          ST_ACK_ADDR: begin
            if (scl_fall) begin
              sda_oe_q <= 1'b0;
              scl_oe_q <= 1'b1;
              state_q <= ST_STRETCH;
            end
          end
          ST_STRETCH: begin
            if (svc) begin
              // Drive the first bit a cycle before letting the clock go
              sda_oe_q <= tx_mode_q & ~tx_byte[7];
              byte_done_q <= 1'b0;
              addr_match_q <= 1'b0;
              cnt_q <= 4'h0;
              state_q <= ST_RELEASE;
            end
          end
          ST_RELEASE: begin
            scl_oe_q <= 1'b0;
            state_q <= ST_DATA;
          end
          ST_DATA: begin
            if (scl_rise) begin
              cnt_q <= cnt_q + 4'h1;
              if (cnt_q == `BITS_PER_BYTE - 4'h1) begin
                byte_done_q <= 1'b1;
                irq_q <= main_ctrl_q[`MC_IRQ_ENABLE];
                if (!tx_mode_q) begin
                  data_q <= {sh_data[6:0], sda_lvl};
                end
              end
            end else if (scl_fall) begin
              if (cnt_q == `BITS_PER_BYTE) begin
                sda_oe_q <= ~tx_mode_q & ~ack_to_send_q;
                state_q <= ST_ACK;
              end else if (tx_mode_q) begin
                // Shifter moves this same edge, so take bit six as the next one
                sda_oe_q <= ~sh_data[6];
              end
            end
          end
          ST_ACK: begin
            if (scl_rise & tx_mode_q) begin
              ack_received_q <= sda_lvl;
            end else if (scl_fall) begin
              sda_oe_q <= 1'b0;
              if (tx_mode_q & ack_received_q) begin
                state_q <= ST_WAIT_STOP;
              end else begin
                scl_oe_q <= 1'b1;
                state_q <= ST_STRETCH;
              end
            end
          end
          ST_WAIT_STOP: begin
            sda_oe_q <= 1'b0;
            scl_oe_q <= 1'b0;
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign scl_o = scl_o_q;
  assign scl_oe_o = scl_oe_q;
  assign sda_o = sda_o_q;
  assign sda_oe_o = sda_oe_q;
  assign bus_irq_o = irq_q;
  wire unused_msb = sh_msb;
endmodule // two_wire_slave_interface

/* testbench/twi_slave_asserts.sv */
`timescale 1ns/100ps
module twi_slave_asserts (
  input wire ref_clk_i,
  input wire srst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  input wire scl_i,
  input wire scl_oe_o,
  input wire sda_i,
  input wire sda_oe_o,
  input wire bus_irq_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);
  logic [7:0] mc_q;
  logic busy_q;
  logic scl_q;
  logic sda_q;
  wire done = psel_i && penable_i && pready_o;
  wire svc = done && paddr_i == 8'h00;
  wire act = mc_q[1] && mc_q[7:5] == 3'h6;
  always_ff @(posedge ref_clk_i) begin
    scl_q <= scl_i;
    sda_q <= sda_i;
    if (srst_i) begin
      mc_q <= 8'h00;
      busy_q <= 1'b0;
    end else begin
      if (done && pwrite_i && paddr_i == 8'h0C) mc_q <= pwdata_i[7:0];
      // Old data level tells START (was high) from STOP (was low)
      if (scl_i && scl_q && sda_i != sda_q) busy_q <= sda_q;
    end
  end
  sequence acc_s;
    psel_i && penable_i && !pready_o;
  endsequence
  sequence served_s;
    $past(svc) || $past(svc, 2);
  endsequence
  ready_wait_a: assert property (acc_s |=> pready_o)
    else $error("pready late");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("pready stuck");
  err_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("lone pslverr");
  idle_float_a: assert property ((!act)[*3] |-> !sda_oe_o && !scl_oe_o)
    else $error("lines driven while off");
  data_low_a: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data moved with clock high");
  stretch_hold_a: assert property (scl_oe_o && act && !svc && !$past(svc) |=> scl_oe_o)
    else $error("stretch dropped early");
  stretch_free_a: assert property ($fell(scl_oe_o) && act |-> served_s)
    else $error("stretch ended unserved");
  irq_pulse_a: assert property (bus_irq_o |=> !bus_irq_o)
    else $error("irq too long");
  irq_gate_a: assert property (bus_irq_o |-> mc_q[0] && act)
    else $error("irq while masked");
  busy_read_a: assert property (
    done && !pwrite_i && paddr_i == 8'h08 && act |-> prdata_o[5] == busy_q)
    else $error("busy flag wrong");
endmodule // twi_slave_asserts

/* testbench/twi_master_model.sv */
`timescale 1ns/100ps
module twi_master_model (
  input wire ref_clk_i,
  input wire slow_i,
  input wire scl_oe_i,
  input wire sda_oe_i,
  output wire scl_o,
  output wire sda_o,
  output logic hang_o
);
  logic scl_low_q = 1'b0;
  logic sda_low_q = 1'b0;
  initial hang_o = 1'b0;
  // Pull-ups: a released line reads high, not the last driven value
  assign scl_o = !(scl_low_q || scl_oe_i);
  assign sda_o = !(sda_low_q || sda_oe_i);
  task automatic tick(input int n);
    repeat (slow_i ? 2 * n : n) @(posedge ref_clk_i);
  endtask
  // Slave may stretch; a stuck clock is flagged rather than waited on forever
  task automatic rise();
    int i;
    scl_low_q <= 1'b0;
    for (i = 0; i < 4000 && scl_o !== 1'b1; i++) @(posedge ref_clk_i);
    if (scl_o !== 1'b1) hang_o <= 1'b1;
    tick(8);
  endtask
  task automatic bit_x(input logic b, output logic s);
    tick(2);
    sda_low_q <= !b;
    tick(6);
    rise();
    s = sda_o;
    scl_low_q <= 1'b1;
  endtask
  task automatic xfer(input logic [7:0] t, input logic a, output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--) bit_x(t[i], r[i]);
    bit_x(a, k);
  endtask
  task automatic start();
    sda_low_q <= 1'b1;
    tick(8);
    scl_low_q <= 1'b1;
  endtask
  task automatic stop();
    tick(2);
    sda_low_q <= 1'b1;
    tick(6);
    rise();
    sda_low_q <= 1'b0;
    tick(8);
  endtask
endmodule // twi_master_model

/* testbench/two_wire_slave_interface_test.sv */
`timescale 1ns/100ps
module two_wire_slave_interface_test;
  logic ref_clk_i = 1'b0, srst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic slow = 1'b0, e, ack;
  wire [31:0] prdata_o;
  wire pready_o, pslverr_o, scl_o, scl_oe_o, sda_o, sda_oe_o, bus_irq_o, scl_i, sda_i, hang;
  int fail_count = 0, compares = 0, irqs = 0, k;
  logic [31:0] r;
  logic [7:0] rx, adr, dat;
  logic [7:0] q[$];
  two_wire_slave_interface dut (.ref_clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .scl_i, .scl_o, .scl_oe_o,
    .sda_i, .sda_o, .sda_oe_o, .bus_irq_o);
  twi_master_model m (.ref_clk_i, .slow_i(slow), .scl_oe_i(scl_oe_o), .sda_oe_i(sda_oe_o),
    .scl_o(scl_i), .sda_o(sda_i), .hang_o(hang));
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    if (bus_irq_o === 1'b1) irqs++;
  end
  task automatic end_sim();
    if (hang === 1'b1) fail_count++;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] x, input logic [31:0] g, input string s);
    compares++;
    if (g !== x) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h0, d};
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    for (i = 0; i < 50 && pready_o !== 1'b1; i++) @(posedge ref_clk_i);
    if (i == 50) begin
      fail_count++;
      end_sim();
    end
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic xb(input logic [7:0] t, input logic a);
    m.xfer(t, a, rx, ack);
    if (hang === 1'b1) begin
      fail_count++;
      end_sim();
    end
  endtask
  task automatic st(input logic [7:0] msk, input logic [7:0] x);
    apb(1'b0, 8'h08, 8'h00);
    chk(x, r & msk, "status");
  endtask
  initial begin
    void'($urandom(70343));
    adr = 8'($urandom_range(127, 1));
    repeat (20) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    @(posedge ref_clk_i);
    apb(1'b0, 8'h04, 8'h00);
    chk(0, r, "address reset");
    apb(1'b0, 8'h10, 8'h55);
    chk(1, e, "unmapped error");
    chk(0, r, "unmapped data");
    apb(1'b1, 8'h04, {adr[6:0], 1'b1});
    apb(1'b0, 8'h04, 8'h00);
    chk(adr[6:0], r[7:1], "address");
    apb(1'b1, 8'h0C, 8'hC2);
    apb(1'b1, 8'h0C, 8'hC3);
    $display("test registers done");
    m.start();
    st(8'h20, 8'h20);
    xb({adr[6:0], 1'b0}, 1'b1);
    chk(0, ack, "address ack");
    st(8'h64, 8'h60);
    chk(1, scl_oe_o, "stretch");
    apb(1'b0, 8'h00, 8'h00);
    for (k = 0; k < 2; k++) begin
      apb(1'b1, 8'h08, k ? 8'h08 : 8'h00);
      dat = 8'($urandom);
      q.push_back(dat);
      xb(dat, 1'b1);
      chk(k, ack, "rx ack");
      st(8'hC0, 8'h80);
      apb(1'b0, 8'h00, 8'h00);
      chk(q.pop_front(), r, "rx data");
    end
    m.stop();
    st(8'h20, 8'h00);
    $display("test master write done");
    m.start();
    xb({adr[6:0] ^ 7'h40, 1'b0}, 1'b1);
    chk(1, ack, "other address ack");
    st(8'h40, 8'h00);
    m.stop();
    $display("test other address done");
    apb(1'b1, 8'h0C, 8'hC2);
    slow <= 1'b1;
    m.start();
    xb({adr[6:0], 1'b1}, 1'b1);
    chk(0, ack, "read address ack");
    st(8'h44, 8'h44);
    apb(1'b1, 8'h08, 8'h10);
    for (k = 0; k < 2; k++) begin
      dat = 8'($urandom);
      q.push_back(dat);
      apb(1'b1, 8'h00, dat);
      xb(8'hFF, k[0]);
      chk(q.pop_front(), rx, "tx data");
      st(8'h81, {7'h40, k[0]});
    end
    chk(0, sda_oe_o, "tx release");
    m.stop();
    chk(3, irqs, "irq count");
    $display("test master read done");
    apb(1'b1, 8'h0C, 8'h00);
    m.start();
    st(8'h20, 8'h00);
    chk(0, {scl_o, sda_o, scl_oe_o, sda_oe_o}, "lines off");
    apb(1'b1, 8'h0C, 8'h22);
    m.stop();
    m.start();
    st(8'h20, 8'h00);
    chk(0, {scl_oe_o, sda_oe_o}, "wrong mode lines");
    m.stop();
    $display("test disabled done");
    end_sim();
  end
endmodule // two_wire_slave_interface_test
bind two_wire_slave_interface twi_slave_asserts chk_i (.ref_clk_i, .srst_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .scl_i,
  .scl_oe_o, .sda_i, .sda_oe_o, .bus_irq_o);
